// file: rtl/motor_control_pwm_timer.sv
// Advanced motor-control timer: prescaled 16-bit counter, four channels,
// three dead-time pairs, encoder and hall inputs, timer linking.
// Assumes an AHB-Lite master with single word transfers; pins are
// synchronous to clk_i.
//
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module motor_control_pwm_timer (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic [31:0] hrdata_o,
  output logic hresp_o,
  input wire logic [3:0] cap_i,
  input wire logic [2:0] hall_i,
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  input wire logic trig_i,
  input wire logic dbg_halt_i,
  output logic [3:0] pwm_o,
  output logic [2:0] pwm_n_o,
  output logic trgo_o,
  output logic dma_req_o,
  output logic irq_o
);
  logic [tmr_pkg::CTRL_W-1:0] ctrl;
  logic [15:0] psc;
  logic [15:0] arr;
  logic [15:0] cnt;
  logic [15:0] psc_cnt;
  logic [15:0] chmode;
  logic [7:0] dead;
  logic [15:0] cmp [tmr_pkg::NCH];
  logic [tmr_pkg::IRQ_W-1:0] status;
  logic [tmr_pkg::IRQ_W-1:0] ien;
  logic [tmr_pkg::IRQ_W-1:0] ev;
  logic [tmr_pkg::IRQ_W-1:0] clr;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic take;
  logic [31:0] rd_val;
  logic cdir;
  logic run;
  logic tick;
  logic cstep;
  logic up_now;
  logic upd;
  logic center;
  logic trig_rst;
  logic enc_a_q;
  logic enc_b_q;
  logic enc_step;
  logic out_on;
  logic [3:0] src;
  logic [3:0] src_q;
  logic [3:0] cap_ev;
  logic [3:0] match;
  logic [3:0] ref_lvl;
  logic [2:0] pair_hi;
  logic [2:0] pair_lo;
  logic pwm3;
  logic [1:0] cmode;

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  // Zero-wait slave: writes land in the data phase, reads are sampled
  // in the address phase, so a read directly behind a write to the same
  // register would see the old value.
  assign take = hsel_i && htrans_i[1] && hready_i;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= take && hwrite_i;
      wr_addr <= haddr_i[7:0];
    end
  end

  always_comb begin
    rd_val = 32'h0;
    case (haddr_i[7:0])
      tmr_pkg::OFF_CTRL: rd_val[tmr_pkg::CTRL_W-1:0] = ctrl;
      tmr_pkg::OFF_PSC: rd_val[15:0] = psc;
      tmr_pkg::OFF_ARR: rd_val[15:0] = arr;
      tmr_pkg::OFF_CNT: rd_val[15:0] = cnt;
      tmr_pkg::OFF_CHMODE: rd_val[15:0] = chmode;
      tmr_pkg::OFF_DEAD: rd_val[7:0] = dead;
      tmr_pkg::OFF_STAT: rd_val[tmr_pkg::IRQ_W-1:0] = status;
      tmr_pkg::OFF_IEN: rd_val[tmr_pkg::IRQ_W-1:0] = ien;
      default: begin
        if (haddr_i[7:4] == tmr_pkg::OFF_CMP0[7:4]) begin
          rd_val[15:0] = cmp[haddr_i[3:2]];
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hrdata_o <= 32'h0;
    end else if (take && !hwrite_i) begin
      hrdata_o <= rd_val;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      psc <= tmr_pkg::PSC_RST;
      arr <= tmr_pkg::ARR_RST;
      chmode <= 16'h0;
      dead <= 8'h0;
      ien <= '0;
    end else if (wr_pend) begin
      case (wr_addr)
        tmr_pkg::OFF_PSC: psc <= hwdata_i[15:0];
        tmr_pkg::OFF_ARR: arr <= hwdata_i[15:0];
        tmr_pkg::OFF_CHMODE: chmode <= hwdata_i[15:0];
        tmr_pkg::OFF_DEAD: dead <= hwdata_i[7:0];
        tmr_pkg::OFF_IEN: ien <= hwdata_i[tmr_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Control and linking
  // ---------------------------------------------------------------
  assign trig_rst = trig_i && ctrl[tmr_pkg::B_TRIG];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl <= '0;
    end else begin
      if (wr_pend && wr_addr == tmr_pkg::OFF_CTRL) begin
        ctrl <= hwdata_i[tmr_pkg::CTRL_W-1:0];
      end
      if (upd && ctrl[tmr_pkg::B_OPM]) begin
        ctrl[tmr_pkg::B_EN] <= 1'b0;
      end
      if (trig_rst) begin
        ctrl[tmr_pkg::B_EN] <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Prescaler and counter
  // ---------------------------------------------------------------
  assign cmode = ctrl[tmr_pkg::B_DIR +: 2];
  assign center = (cmode == tmr_pkg::CM_CENTER) && !ctrl[tmr_pkg::B_ENC];
  assign run = ctrl[tmr_pkg::B_EN]
    && !(dbg_halt_i && ctrl[tmr_pkg::B_FRZ]);
  assign tick = run && !ctrl[tmr_pkg::B_ENC] && (psc_cnt >= psc);
  assign enc_step = (enc_a_i ^ enc_a_q) ^ (enc_b_i ^ enc_b_q);
  assign cstep = tick || (run && ctrl[tmr_pkg::B_ENC] && enc_step);

  always_comb begin
    if (ctrl[tmr_pkg::B_ENC]) begin
      up_now = enc_a_q ^ enc_b_i;
    end else begin
      case (cmode)
        tmr_pkg::CM_DOWN: up_now = 1'b0;
        tmr_pkg::CM_CENTER: up_now = cdir;
        default: up_now = 1'b1;
      endcase
    end
  end

  assign upd = cstep && (up_now ? (cnt >= arr) : (cnt == 16'h0));

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      psc_cnt <= 16'h0;
      enc_a_q <= 1'b0;
      enc_b_q <= 1'b0;
    end else begin
      enc_a_q <= enc_a_i;
      enc_b_q <= enc_b_i;
      if (trig_rst) begin
        psc_cnt <= 16'h0;
      end else if (run && !ctrl[tmr_pkg::B_ENC]) begin
        psc_cnt <= (psc_cnt >= psc) ? 16'h0 : psc_cnt + 16'h1;
      end
    end
  end

  // Centre mode turns without repeating the end value, so one period
  // is two times the auto-reload value in counter steps.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 16'h0;
      cdir <= 1'b1;
    end else if (wr_pend && wr_addr == tmr_pkg::OFF_CNT) begin
      cnt <= hwdata_i[15:0];
    end else if (trig_rst) begin
      cnt <= 16'h0;
      cdir <= 1'b1;
    end else if (cstep) begin
      if (up_now) begin
        if (cnt >= arr) begin
          if (center) begin
            cnt <= (cnt == 16'h0) ? 16'h0 : cnt - 16'h1;
            cdir <= 1'b0;
          end else begin
            cnt <= 16'h0;
          end
        end else begin
          cnt <= cnt + 16'h1;
        end
      end else if (cnt == 16'h0) begin
        if (center) begin
          cnt <= (arr == 16'h0) ? 16'h0 : 16'h1;
          cdir <= 1'b1;
        end else begin
          cnt <= arr;
        end
      end else begin
        cnt <= cnt - 16'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------
  // Hall mode feeds the xor of all sensors into channel 0, so any
  // sensor edge captures the counter; unused sensors are tied still.
  always_comb begin
    src = cap_i;
    if (ctrl[tmr_pkg::B_HALL]) begin
      src[0] = ^hall_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_q <= 4'h0;
    end else begin
      src_q <= src;
    end
  end

  genvar k;
  generate
    for (k = 0; k < tmr_pkg::NCH; k++) begin : g_ch
      logic [2:0] chm;
      logic edge_seen;
      assign chm = chmode[k*tmr_pkg::CHM_STRIDE +: 3];
      assign edge_seen = (k == 0 && ctrl[tmr_pkg::B_HALL])
        ? (src[k] ^ src_q[k]) : (src[k] & ~src_q[k]);
      assign cap_ev[k] = run && chm == tmr_pkg::CH_CAP && edge_seen;
      assign match[k] = cstep && cnt == cmp[k]
        && (chm == tmr_pkg::CH_TOG || chm == tmr_pkg::CH_PWM);

      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          cmp[k] <= 16'h0;
        end else if (cap_ev[k]) begin
          cmp[k] <= cnt;
        end else if (wr_pend && wr_addr == tmr_pkg::OFF_CMP0 + 8'(4*k)) begin
          cmp[k] <= hwdata_i[15:0];
        end
      end

      // PWM is active below the compare value, so a compare of zero is
      // always off and one above the reload value is always on.
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          ref_lvl[k] <= 1'b0;
        end else begin
          case (chm)
            tmr_pkg::CH_PWM: begin
              ref_lvl[k] <= ctrl[tmr_pkg::B_EN] && (cnt < cmp[k]);
            end
            tmr_pkg::CH_TOG: begin
              if (match[k]) begin
                ref_lvl[k] <= ~ref_lvl[k];
              end
            end
            tmr_pkg::CH_HIGH: ref_lvl[k] <= 1'b1;
            default: ref_lvl[k] <= 1'b0;
          endcase
        end
      end

      a_capture_value: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        cap_ev[k] |=> cmp[k] == $past(cnt))
        else $error("Capture did not latch the counter.");
    end
  endgenerate

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign out_on = ctrl[tmr_pkg::B_MOE]
    && !(dbg_halt_i && ctrl[tmr_pkg::B_DBGOFF]);

  generate
    for (k = 0; k < tmr_pkg::NPAIR; k++) begin : g_pair
      dt_if link ();
      assign link.ref_lvl = ref_lvl[k];
      assign link.dead = dead;
      assign link.en = out_on;
      dead_time u_dt (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .g(link.gen)
      );
      assign pair_hi[k] = link.hi;
      assign pair_lo[k] = link.lo;
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwm3 <= 1'b0;
      trgo_o <= 1'b0;
      dma_req_o <= 1'b0;
    end else begin
      pwm3 <= ref_lvl[3] && out_on;
      trgo_o <= upd;
      dma_req_o <= upd && ctrl[tmr_pkg::B_DMA];
    end
  end

  assign pwm_o = {pwm3, pair_hi};
  assign pwm_n_o = pair_lo;

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  assign ev = {trig_rst, cap_ev | match, upd};
  assign clr = (wr_pend && wr_addr == tmr_pkg::OFF_CLR)
    ? hwdata_i[tmr_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status <= '0;
    end else begin
      status <= (status & ~clr) | ev;
    end
  end

  assign irq_o = |(status & ien);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  logic quiet;
  assign quiet = !wr_pend && !trig_rst;

  sequence s_up_top;
    cstep && up_now && cnt >= arr && !center && quiet;
  endsequence
  sequence s_down_bot;
    cstep && !up_now && cnt == 16'h0 && !center && quiet;
  endsequence

  a_psc_spacing: assert property (
    tick && psc != 16'h0 && quiet |=> !tick)
    else $error("Prescaler ticked twice in a row.");
  a_up_wrap: assert property (s_up_top |=> cnt == 16'h0 && trgo_o)
    else $error("Up count did not wrap with update.");
  a_down_reload: assert property (
    s_down_bot |=> cnt == $past(arr) && trgo_o)
    else $error("Down count did not reload.");
  a_center_turn: assert property (
    center && cstep && cdir && cnt >= arr && arr != 16'h0 && quiet
    |=> !cdir && cnt == $past(cnt) - 16'h1)
    else $error("Centre count did not turn at the top.");
  a_pwm_full: assert property (
    chmode[2:0] == tmr_pkg::CH_PWM && ctrl[tmr_pkg::B_EN]
    && cmp[0] > arr && cnt <= arr |=> ref_lvl[0])
    else $error("Full duty PWM went inactive.");
  a_pwm_zero: assert property (
    chmode[2:0] == tmr_pkg::CH_PWM && cmp[0] == 16'h0 |=> !ref_lvl[0])
    else $error("Zero duty PWM went active.");
  a_debug_off: assert property (
    dbg_halt_i && ctrl[tmr_pkg::B_DBGOFF] |=> pwm_o == 4'h0
    && pwm_n_o == 3'h0)
    else $error("Outputs active during debug halt.");
  a_debug_freeze: assert property (
    dbg_halt_i && ctrl[tmr_pkg::B_FRZ] && quiet |=> $stable(cnt))
    else $error("Counter moved while frozen.");
  a_one_pulse: assert property (
    upd && ctrl[tmr_pkg::B_OPM] && quiet |=> !ctrl[tmr_pkg::B_EN])
    else $error("One-pulse mode did not stop.");
  a_trig_start: assert property (
    trig_rst && !wr_pend |=> cnt == 16'h0 && ctrl[tmr_pkg::B_EN])
    else $error("Link trigger did not restart the counter.");
  a_update_sticky: assert property (
    upd |=> status[tmr_pkg::IRQ_UPD]
    ##1 (status[tmr_pkg::IRQ_UPD] || $past(clr[tmr_pkg::IRQ_UPD])))
    else $error("Update flag lost.");
  a_dma_request: assert property (
    upd && ctrl[tmr_pkg::B_DMA] |=> dma_req_o)
    else $error("Update gave no DMA request.");
endmodule : motor_control_pwm_timer
`default_nettype wire

// file: rtl/tmr_pkg.sv
// Register map, field layout and encodings of the motor-control PWM timer.
// Assumes one 100 MHz clock and word-wide AHB-Lite register access.
package tmr_pkg;
  localparam int CW = 16;
  localparam int DTW = 8;
  localparam int NCH = 4;
  localparam int NPAIR = 3;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PSC = 8'h04;
  localparam logic [7:0] OFF_ARR = 8'h08;
  localparam logic [7:0] OFF_CNT = 8'h0c;
  localparam logic [7:0] OFF_CHMODE = 8'h10;
  localparam logic [7:0] OFF_DEAD = 8'h14;
  localparam logic [7:0] OFF_CMP0 = 8'h20;
  localparam logic [7:0] OFF_STAT = 8'h30;
  localparam logic [7:0] OFF_CLR = 8'h34;
  localparam logic [7:0] OFF_IEN = 8'h38;

  // ---------------------------------------------------------------
  // Control fields
  // ---------------------------------------------------------------
  localparam int B_EN = 0;
  localparam int B_DIR = 1;
  localparam int B_OPM = 3;
  localparam int B_ENC = 4;
  localparam int B_HALL = 5;
  localparam int B_FRZ = 6;
  localparam int B_DBGOFF = 7;
  localparam int B_TRIG = 8;
  localparam int B_MOE = 9;
  localparam int B_DMA = 10;
  localparam int CTRL_W = 11;

  localparam logic [1:0] CM_UP = 2'h0;
  localparam logic [1:0] CM_DOWN = 2'h1;
  localparam logic [1:0] CM_CENTER = 2'h2;

  localparam int CHM_STRIDE = 4;
  localparam logic [2:0] CH_OFF = 3'h0;
  localparam logic [2:0] CH_CAP = 3'h1;
  localparam logic [2:0] CH_TOG = 3'h2;
  localparam logic [2:0] CH_PWM = 3'h3;
  localparam logic [2:0] CH_LOW = 3'h4;
  localparam logic [2:0] CH_HIGH = 3'h5;

  localparam int IRQ_UPD = 0;
  localparam int IRQ_CC0 = 1;
  localparam int IRQ_TRG = 5;
  localparam int IRQ_W = 6;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [CW-1:0] ARR_RST = 16'hffff;
  localparam logic [CW-1:0] PSC_RST = 16'h0000;
endpackage : tmr_pkg

// file: rtl/dt_if.sv
// Carrier between the timer core and one dead-time generator.
// Assumes both ends run on the timer clock.
`timescale 1ns/100ps
`default_nettype none
interface dt_if;
  logic ref_lvl;
  logic [tmr_pkg::DTW-1:0] dead;
  logic en;
  logic hi;
  logic lo;
  modport core (output ref_lvl, output dead, output en, input hi, input lo);
  modport gen (input ref_lvl, input dead, input en, output hi, output lo);
endinterface : dt_if
`default_nettype wire

// file: rtl/dead_time.sv
// Dead-time generator for one complementary output pair.
// Assumes the reference level and dead count come from the timer core.
`timescale 1ns/100ps
`default_nettype none
module dead_time (
  input wire logic clk_i,
  input wire logic rst_n_i,
  dt_if.gen g
);
  logic ref_q;
  logic hi;
  logic lo;
  logic [tmr_pkg::DTW-1:0] left;

  // ---------------------------------------------------------------
  // Pair sequencing
  // ---------------------------------------------------------------
  // Any edge of the reference drops both sides first, so a zero dead
  // count still leaves one idle cycle and the bridge never shoots through.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_q <= 1'b0;
      hi <= 1'b0;
      lo <= 1'b0;
      left <= '0;
    end else begin
      ref_q <= g.ref_lvl;
      if (g.ref_lvl != ref_q) begin
        left <= g.dead;
        hi <= 1'b0;
        lo <= 1'b0;
      end else if (left != '0) begin
        left <= left - 8'h01;
      end else begin
        hi <= g.ref_lvl & g.en;
        lo <= ~g.ref_lvl & g.en;
      end
    end
  end

  assign g.hi = hi;
  assign g.lo = lo;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_ref_edge;
    $changed(g.ref_lvl);
  endsequence

  a_pair_exclusive: assert property (!(hi && lo))
    else $error("Both pair outputs active.");
  a_edge_blank: assert property (s_ref_edge |=> !hi && !lo)
    else $error("Pair output active right after reference edge.");
  a_dead_wait: assert property (
    s_ref_edge and (g.dead >= 8'h02) |=> (!hi && !lo) [*2])
    else $error("Pair output active before dead time expired.");
endmodule : dead_time
`default_nettype wire

// file: sim/motor_bridge_model.sv
// Model of the bridge, encoder and hall sensors beside the timer.
// Assumes registered pin outputs that are settled by the falling edge.
`timescale 1ns/100ps
`default_nettype none
module motor_bridge_model (
  input wire logic clk_i,
  input wire logic [2:0] hi_i,
  input wire logic [2:0] lo_i,
  input wire logic step_i,
  output logic enc_a_o,
  output logic enc_b_o,
  output logic [2:0] hall_o,
  output int overlap_o,
  output int gap_o
);
  logic [1:0] ph = 2'h0;
  int run = 0;
  int ovl_n = 0;
  int gap_n = 0;
  // Gray sequence, so only one encoder line changes per step.
  assign enc_a_o = ph[1];
  assign enc_b_o = ph[1] ^ ph[0];
  // Two hall sensors on the same Gray phase, so each step flips one.
  assign hall_o = {ph[1], ph[1] ^ ph[0], 1'b0};
  assign overlap_o = ovl_n;
  assign gap_o = gap_n;
  always @(posedge clk_i) begin
    if (step_i) ph <= ph + 2'h1;
  end
  // Both switches on at once would short the supply rail.
  always @(negedge clk_i) begin
    if (|(hi_i & lo_i)) ovl_n++;
    if (!hi_i[0] && !lo_i[0]) run++;
    else begin
      if (run > 0) gap_n = run;
      run = 0;
    end
  end
endmodule : motor_bridge_model
`default_nettype wire

// file: sim/motor_control_pwm_timer_tb.sv
// Self-checking bench of the motor-control PWM timer.
// Assumes the bridge model on the pins and a zero-wait AHB-Lite slave.
`timescale 1ns/100ps
`default_nettype none
module motor_control_pwm_timer_tb;
  logic clk_i = 1'b0, rst_n_i = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0] htrans = 2'h0;
  logic [3:0] cap = 4'h0;
  logic trig = 1'b0, halt = 1'b0, step = 1'b0;
  logic hready, enc_a, enc_b, trgo, dma, irq, hresp;
  logic [31:0] hrdata;
  logic [2:0] hall, pwm_n;
  logic [3:0] pwm;
  int error_cnt = 0, comparisons = 0, ovl, gap, n, k, c, m, p, a;
  integer seed = 32'hd4c8;
  always #5 clk_i = ~clk_i;
  motor_control_pwm_timer i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hreadyout_o(hready), .hrdata_o(hrdata), .hresp_o(hresp), .cap_i(cap),
    .hall_i(hall), .enc_a_i(enc_a), .enc_b_i(enc_b), .trig_i(trig),
    .dbg_halt_i(halt), .pwm_o(pwm), .pwm_n_o(pwm_n), .trgo_o(trgo),
    .dma_req_o(dma), .irq_o(irq));
  motor_bridge_model i_bridge (.clk_i(clk_i), .hi_i(pwm[2:0]),
    .lo_i(pwm_n), .step_i(step), .enc_a_o(enc_a), .enc_b_o(enc_b),
    .hall_o(hall), .overlap_o(ovl), .gap_o(gap));
  // ---------------------------------------------------------------
  // Bus cycles, checks and expectations
  // ---------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] ad,
                      input logic [31:0] d);
    @(posedge clk_i);
    hsel <= 1'b1;
    haddr <= {24'h0, ad};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk_i); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic print_verdict;
    $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  function automatic logic [31:0] bv(input int b);
    return 32'h1 << b;
  endfunction : bv
  function automatic int exp_per(input int md, ps, ar);
    return (md == 2) ? ar * (ps + 1) : (ar + 1) * (ps + 1);
  endfunction : exp_per
  function automatic int exp_duty(input int cm, ar);
    return (cm > ar) ? 100 : cm * 10;
  endfunction : exp_duty
  // Cycles between two update pulses; the second interval is used
  // because the first may start from a stale prescaler phase.
  task automatic per(output int len);
    int i;
    for (i = 0; i < 4000 && trgo !== 1'b1; i++) @(negedge clk_i);
    len = 0;
    do begin
      @(negedge clk_i);
      len++;
    end while (trgo !== 1'b1 && len < 4000);
  endtask : per
  task automatic setup(input int ctl, ps, ar);
    xfer(1, tmr_pkg::OFF_CTRL, 32'h0);
    xfer(1, tmr_pkg::OFF_PSC, ps);
    xfer(1, tmr_pkg::OFF_ARR, ar);
    xfer(1, tmr_pkg::OFF_CNT, 32'h0);
    xfer(1, tmr_pkg::OFF_CTRL, ctl);
  endtask : setup
  initial begin
    #500000;
    error_cnt++;
    print_verdict();
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    xfer(0, tmr_pkg::OFF_ARR, 0);
    chk("arr reset", rd, {16'h0, tmr_pkg::ARR_RST});
    xfer(0, tmr_pkg::OFF_PSC, 0);
    chk("psc reset", rd, 32'h0);
    xfer(0, 8'hfc, 0);
    chk("unmapped", rd, 32'h0);
    chk("okay response", hresp, 1'b0);
    for (m = 0; m < 3; m++) begin
      p = {$random(seed)} % 4;
      a = 4 + {$random(seed)} % 8;
      setup(bv(tmr_pkg::B_EN) | bv(tmr_pkg::B_DMA) | (m << tmr_pkg::B_DIR),
            p, a);
      per(n);
      per(n);
      chk("period", n, exp_per(m, p, a));
      chk("dma with update", dma, 1'b1);
      chk("update pulse", trgo, 1'b1);
    end
    // Corner 16-bit prescale, counter enabled but first tick far off: no update may come.
    setup(bv(tmr_pkg::B_EN), 32'hffff, 1);
    xfer(1, tmr_pkg::OFF_CLR, 32'h3f);
    xfer(0, tmr_pkg::OFF_PSC, 0);
    chk("psc full", rd, 32'hffff);
    xfer(0, tmr_pkg::OFF_STAT, 0);
    chk("no early update", rd[tmr_pkg::IRQ_UPD], 1'b0);
    xfer(1, tmr_pkg::OFF_IEN, bv(tmr_pkg::IRQ_UPD));
    setup(bv(tmr_pkg::B_EN), 0, 5);
    repeat (20) @(posedge clk_i);
    xfer(1, tmr_pkg::OFF_CTRL, 0);
    @(negedge clk_i);
    chk("irq set", irq, 1'b1);
    xfer(1, tmr_pkg::OFF_IEN, 0);
    @(negedge clk_i);
    chk("irq masked", irq, 1'b0);
    xfer(1, tmr_pkg::OFF_IEN, bv(tmr_pkg::IRQ_UPD));
    xfer(1, tmr_pkg::OFF_CLR, 32'h3f);
    @(negedge clk_i);
    chk("irq cleared", irq, 1'b0);
    xfer(0, tmr_pkg::OFF_STAT, 0);
    chk("stat cleared", rd, 32'h0);
    xfer(1, tmr_pkg::OFF_CHMODE, {tmr_pkg::CH_PWM, 12'h0} | tmr_pkg::CH_PWM);
    for (k = 0; k < 5; k++) begin
      c = (k == 0) ? 0 : (k == 1) ? 10 : {$random(seed)} % 12;
      xfer(1, tmr_pkg::OFF_CMP0 + 8'hc, c);
      xfer(1, tmr_pkg::OFF_CMP0, c);
      setup(bv(tmr_pkg::B_EN) | bv(tmr_pkg::B_MOE), 0, 9);
      repeat (20) @(negedge clk_i);
      n = 0;
      repeat (100) begin
        @(negedge clk_i);
        n += pwm[3];
      end
      chk("duty", n, exp_duty(c, 9));
    end
    xfer(1, tmr_pkg::OFF_CHMODE, {tmr_pkg::CH_HIGH, 12'h0});
    repeat (3) @(negedge clk_i);
    chk("forced high", pwm[3], 1'b1);
    xfer(1, tmr_pkg::OFF_CMP0 + 8'hc, 4);
    xfer(1, tmr_pkg::OFF_CHMODE, {tmr_pkg::CH_TOG, 12'h0});
    repeat (3) @(negedge clk_i);
    n = 0;
    p = pwm[3];
    repeat (100) begin
      @(negedge clk_i);
      n += (pwm[3] != p);
      p = pwm[3];
    end
    chk("toggle count", n, 10);
    xfer(1, tmr_pkg::OFF_CHMODE, {tmr_pkg::CH_LOW, 12'h0});
    repeat (3) @(negedge clk_i);
    chk("forced low", pwm[3], 1'b0);
    xfer(1, tmr_pkg::OFF_CHMODE, {tmr_pkg::CH_PWM, 12'h0} | tmr_pkg::CH_PWM);
    xfer(1, tmr_pkg::OFF_CMP0, 25);
    xfer(1, tmr_pkg::OFF_DEAD, 3);
    setup(bv(tmr_pkg::B_EN) | bv(tmr_pkg::B_MOE) | bv(tmr_pkg::B_FRZ) |
          bv(tmr_pkg::B_DBGOFF) | (2 << tmr_pkg::B_DIR), 0, 49);
    repeat (300) @(posedge clk_i);
    chk("dead gap", gap, 4);
    halt <= 1'b1;
    repeat (3) @(negedge clk_i);
    chk("halt outputs", {pwm, pwm_n}, 7'h0);
    xfer(0, tmr_pkg::OFF_CNT, 0);
    n = rd;
    repeat (5) @(posedge clk_i);
    xfer(0, tmr_pkg::OFF_CNT, 0);
    chk("halt freeze", rd, n);
    halt <= 1'b0;
    repeat (200) @(posedge clk_i);
    chk("overlap", ovl, 0);
    setup(bv(tmr_pkg::B_OPM) | bv(tmr_pkg::B_TRIG), 0, 9);
    @(posedge clk_i);
    trig <= 1'b1;
    @(posedge clk_i);
    trig <= 1'b0;
    xfer(0, tmr_pkg::OFF_CTRL, 0);
    chk("trigger start", rd[tmr_pkg::B_EN], 1'b1);
    repeat (30) @(posedge clk_i);
    xfer(0, tmr_pkg::OFF_CTRL, 0);
    chk("one pulse stop", rd[tmr_pkg::B_EN], 1'b0);
    xfer(1, tmr_pkg::OFF_CHMODE, {tmr_pkg::CH_CAP, 4'h0});
    setup(bv(tmr_pkg::B_EN), 0, 32'hffff);
    xfer(1, tmr_pkg::OFF_CLR, 32'h3f);
    cap <= 4'h2;
    repeat (4) @(posedge clk_i);
    cap <= 4'h0;
    xfer(0, tmr_pkg::OFF_STAT, 0);
    chk("capture", rd[tmr_pkg::IRQ_CC0 + 1], 1'b1);
    xfer(1, tmr_pkg::OFF_CHMODE, tmr_pkg::CH_CAP);
    setup(bv(tmr_pkg::B_EN) | bv(tmr_pkg::B_ENC) | bv(tmr_pkg::B_HALL), 0,
          32'hffff);
    xfer(1, tmr_pkg::OFF_CLR, 32'h3f);
    repeat (8) begin
      step <= 1'b1;
      @(posedge clk_i);
      step <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    repeat (4) @(posedge clk_i);
    xfer(0, tmr_pkg::OFF_CNT, 0);
    chk("encoder", (rd == 8 || rd == 32'hfff8), 1'b1);
    xfer(0, tmr_pkg::OFF_CMP0, 0);
    chk("hall capture", rd, 32'h7);
    xfer(0, tmr_pkg::OFF_STAT, 0);
    chk("hall flag", rd[tmr_pkg::IRQ_CC0], 1'b1);
    print_verdict();
  end
endmodule : motor_control_pwm_timer_tb
`default_nettype wire
